// [bcrf_register_file.v]
// banked processor register file with user and privileged modes
`timescale 1ns/1ps
// What this block does
// - user mode normally; taken exception or interrupt enters privileged mode.
// - every general, system and control register is 32 bits.
// - sixteen visible general registers; lower eight exist twice, upper eight shared.
// - privileged with bank bit set: lower eight map to bank 1, bank 0 via control access.
// - privileged with bank bit clear: lower eight map to bank 0, bank 1 via control access.
// - user mode always maps bank 0; bank 1 unreachable.
// - global base and status reachable always; saved status, return pointer, vector base privileged.
// - bank bit and other status bits change only in privileged mode, except bits 9-8 and 1-0, which user mode can write.
// - multiply-accumulate pair, return link and program counter reachable in both modes.
// - status reset sets mode, bank, mask bits, bits 13-10 ones, reserved zero.
// - reset loads vector base zero and program counter a0000000.
// - reset initialisation applies on power-on and manual reset alike.
// - register zero of the current bank serves as index operand.
// - floating register zero supplies the multiplier value.
// - the mode bit in the status word selects the operating mode.
// - mode bit one is privileged, zero user; forced to one on exception.
// - mask flag one blocks exceptions, zero accepts; set on taking one.
`include "bcrf_regs.vh"

module bcrf_register_file #(
    parameter DATA_W = 32
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [3:0] rd_a_idx,
    output reg [DATA_W-1:0] rd_a_data_ff,
    input wire [3:0] rd_b_idx,
    output reg [DATA_W-1:0] rd_b_data_ff,
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire [DATA_W-1:0] wr_data,
    input wire ctl_rd_en,
    input wire [3:0] ctl_rd_sel,
    input wire ctl_rd_bank,
    output reg [DATA_W-1:0] ctl_rd_data_ff,
    input wire ctl_wr_en,
    input wire [3:0] ctl_wr_sel,
    input wire ctl_wr_bank,
    input wire [DATA_W-1:0] ctl_wr_data,
    output reg ctl_denied_ff,
    input wire pc_load_en,
    input wire [DATA_W-1:0] pc_load_data,
    output reg [DATA_W-1:0] pc_ff,
    input wire fp_zero_wr_en,
    input wire [DATA_W-1:0] fp_zero_wr_data,
    output reg [DATA_W-1:0] fp_reg_zero_ff,
    output reg [DATA_W-1:0] index_reg_zero_ff,
    input wire exc_req,
    output wire exc_ack,
    output wire priv_mode,
    output wire bank_select_bit,
    output wire event_mask_flag,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata_ff,
    output wire avs_waitrequest
);

    // ==========================================================
    // storage
    // entries 0-7 bank 0, 8-15 bank 1, 16-23 shared upper eight
    reg [DATA_W-1:0] gpr [0:23];
    reg [DATA_W-1:0] status_word_ff;
    reg [DATA_W-1:0] saved_status_reg_ff;
    reg [DATA_W-1:0] saved_return_pointer_ff;
    reg [DATA_W-1:0] global_base_pointer_ff;
    reg [DATA_W-1:0] vector_table_base_ff;
    reg [DATA_W-1:0] mult_acc_high_ff;
    reg [DATA_W-1:0] mult_acc_low_ff;
    reg [DATA_W-1:0] subroutine_return_link_ff;
    reg bus_ack_ff;

    reg [DATA_W-1:0] nxt_status_word;
    reg [DATA_W-1:0] nxt_pc;
    reg [DATA_W-1:0] nxt_vbase;
    reg [DATA_W-1:0] ctl_rd_mux;
    reg [31:0] bus_rd_mux;
    reg [31:0] bus_wmask;

    wire bus_req;
    wire bus_wr_do;
    wire ctl_wr_ok;
    wire ctl_rd_ok;
    wire exc_take;
    wire [4:0] wr_phys;
    wire [4:0] ctl_bank_phys;

    assign priv_mode = status_word_ff[`BCRF_SR_MODE];
    assign bank_select_bit = status_word_ff[`BCRF_SR_BANK];
    assign event_mask_flag = status_word_ff[`BCRF_SR_EMASK];

    // ==========================================================
    // decoding helpers
    // maps an instruction-visible index to a storage entry
    function [4:0] gpr_map;
        input [3:0] idx;
        input priv;
        input rb;
        begin
            if (idx[3]) begin
                gpr_map = {2'b10, idx[2:0]};
            end else if (priv && rb) begin
                gpr_map = {2'b01, idx[2:0]};
            end else begin
                gpr_map = {2'b00, idx[2:0]};
            end
        end
    endfunction

    // whether a control or system selector may be touched in this mode
    function ctl_allowed;
        input [3:0] sel;
        input bank;
        input priv;
        begin
            if (bank) begin
                ctl_allowed = priv;
            end else begin
                case (sel)
                    `BCRF_SEL_STATUS, `BCRF_SEL_GBASE: ctl_allowed = 1'b1;
                    `BCRF_SEL_MULT_ACC_HIGH, `BCRF_SEL_MULT_ACC_LOW, `BCRF_SEL_LINK: ctl_allowed = 1'b1;
                    `BCRF_SEL_SSTAT, `BCRF_SEL_SRET, `BCRF_SEL_VBASE: ctl_allowed = priv;
                    default: ctl_allowed = 1'b0;
                endcase
            end
        end
    endfunction

    assign wr_phys = gpr_map(wr_idx, priv_mode, bank_select_bit);
    // the bank not currently mapped, reached only by control access
    assign ctl_bank_phys = {1'b0, ~bank_select_bit, ctl_wr_sel[2:0]};
    assign ctl_wr_ok = ctl_wr_en && ctl_allowed(ctl_wr_sel, ctl_wr_bank, priv_mode);
    assign ctl_rd_ok = ctl_allowed(ctl_rd_sel, ctl_rd_bank, priv_mode);

    // ==========================================================
    // exception entry
    assign exc_take = exc_req && !event_mask_flag;
    assign exc_ack = exc_take;

    // ==========================================================
    // bus slave: one wait state per access
    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !bus_ack_ff;
    assign bus_wr_do = avs_write && bus_ack_ff;

    always @* begin
        bus_wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        case (avs_address[5:2])
            4'h0: bus_rd_mux = status_word_ff;
            4'h1: bus_rd_mux = pc_ff;
            4'h2: bus_rd_mux = vector_table_base_ff;
            4'h3: bus_rd_mux = {29'h0, event_mask_flag, bank_select_bit & priv_mode, priv_mode};
            default: bus_rd_mux = 32'h0;
        endcase
    end

    // ==========================================================
    // next values of the reset-initialised registers
    always @* begin
        nxt_status_word = status_word_ff;
        nxt_pc = pc_ff;
        nxt_vbase = vector_table_base_ff;
        if (ctl_wr_ok && !ctl_wr_bank && ctl_wr_sel == `BCRF_SEL_STATUS) begin
            if (priv_mode) begin
                nxt_status_word = ctl_wr_data & `BCRF_SR_WMASK;
            end else begin
                // user mode touches only the condition bits
                nxt_status_word = (status_word_ff & ~`BCRF_SR_UMASK) |
                                  (ctl_wr_data & `BCRF_SR_UMASK);
            end
        end
        if (ctl_wr_ok && !ctl_wr_bank && ctl_wr_sel == `BCRF_SEL_VBASE) begin
            nxt_vbase = ctl_wr_data;
        end
        if (pc_load_en) begin
            nxt_pc = pc_load_data;
        end
        // debug bus acts with privileged rights, after the core
        if (bus_wr_do) begin
            case (avs_address[5:2])
                4'h0: nxt_status_word = ((status_word_ff & ~bus_wmask) |
                                         (avs_writedata & bus_wmask)) & `BCRF_SR_WMASK;
                4'h1: nxt_pc = (pc_ff & ~bus_wmask) | (avs_writedata & bus_wmask);
                4'h2: nxt_vbase = (vector_table_base_ff & ~bus_wmask) | (avs_writedata & bus_wmask);
                default: nxt_pc = nxt_pc;
            endcase
        end
        if (exc_take) begin
            nxt_status_word = status_word_ff | `BCRF_SR_EVENT;
        end
    end

    // ==========================================================
    // control state with reset; rst_b is the or of power-on and manual reset
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_word_ff <= `BCRF_SR_RESET;
            pc_ff <= `BCRF_PC_RESET;
            vector_table_base_ff <= `BCRF_VBASE_RESET;
            bus_ack_ff <= 1'b0;
            avs_readdata_ff <= 32'h0;
            ctl_denied_ff <= 1'b0;
        end else begin
            status_word_ff <= nxt_status_word;
            pc_ff <= nxt_pc;
            vector_table_base_ff <= nxt_vbase;
            bus_ack_ff <= bus_req && !bus_ack_ff;
            if (avs_read && !bus_ack_ff) begin
                avs_readdata_ff <= bus_rd_mux;
            end
            ctl_denied_ff <= (ctl_wr_en && !ctl_wr_ok) || (ctl_rd_en && !ctl_rd_ok);
        end
    end

    // ==========================================================
    // data registers, left undefined by reset
    always @(posedge sys_clk) begin
        if (wr_en) begin
            gpr[wr_phys] <= wr_data;
        end
        if (ctl_wr_ok && ctl_wr_bank) begin
            gpr[ctl_bank_phys] <= ctl_wr_data;
        end
        if (ctl_wr_ok && !ctl_wr_bank) begin
            case (ctl_wr_sel)
                `BCRF_SEL_GBASE: global_base_pointer_ff <= ctl_wr_data;
                `BCRF_SEL_SSTAT: saved_status_reg_ff <= ctl_wr_data;
                `BCRF_SEL_SRET: saved_return_pointer_ff <= ctl_wr_data;
                `BCRF_SEL_MULT_ACC_HIGH: mult_acc_high_ff <= ctl_wr_data;
                `BCRF_SEL_MULT_ACC_LOW: mult_acc_low_ff <= ctl_wr_data;
                `BCRF_SEL_LINK: subroutine_return_link_ff <= ctl_wr_data;
                default: global_base_pointer_ff <= global_base_pointer_ff;
            endcase
        end
        // exception capture wins over a software write in the same cycle
        if (exc_take) begin
            saved_status_reg_ff <= status_word_ff;
            saved_return_pointer_ff <= pc_ff;
        end
        if (fp_zero_wr_en) begin
            fp_reg_zero_ff <= fp_zero_wr_data;
        end
    end

    // ==========================================================
    // read ports, one cycle latency
    always @* begin
        ctl_rd_mux = {DATA_W{1'b0}};
        if (ctl_rd_bank) begin
            ctl_rd_mux = gpr[{1'b0, ~bank_select_bit, ctl_rd_sel[2:0]}];
        end else begin
            case (ctl_rd_sel)
                `BCRF_SEL_STATUS: ctl_rd_mux = status_word_ff;
                `BCRF_SEL_GBASE: ctl_rd_mux = global_base_pointer_ff;
                `BCRF_SEL_SSTAT: ctl_rd_mux = saved_status_reg_ff;
                `BCRF_SEL_SRET: ctl_rd_mux = saved_return_pointer_ff;
                `BCRF_SEL_VBASE: ctl_rd_mux = vector_table_base_ff;
                `BCRF_SEL_MULT_ACC_HIGH: ctl_rd_mux = mult_acc_high_ff;
                `BCRF_SEL_MULT_ACC_LOW: ctl_rd_mux = mult_acc_low_ff;
                `BCRF_SEL_LINK: ctl_rd_mux = subroutine_return_link_ff;
                default: ctl_rd_mux = {DATA_W{1'b0}};
            endcase
        end
    end

    always @(posedge sys_clk) begin
        rd_a_data_ff <= gpr[gpr_map(rd_a_idx, priv_mode, bank_select_bit)];
        rd_b_data_ff <= gpr[gpr_map(rd_b_idx, priv_mode, bank_select_bit)];
        index_reg_zero_ff <= gpr[gpr_map(4'h0, priv_mode, bank_select_bit)];
        // a refused read returns zero rather than privileged contents
        if (ctl_rd_en) begin
            ctl_rd_data_ff <= ctl_rd_ok ? ctl_rd_mux : {DATA_W{1'b0}};
        end
    end

endmodule // bcrf_register_file

// [bcrf_regs.vh]
// constants of the banked processor register file
`ifndef BCRF_REGS_VH
`define BCRF_REGS_VH

// ==========================================================
// bus register byte offsets
`define BCRF_OFS_STATUS 6'h00
`define BCRF_OFS_PC 6'h04
`define BCRF_OFS_VBASE 6'h08
`define BCRF_OFS_STATE 6'h0c

// ==========================================================
// status word fields
`define BCRF_SR_MODE 30
`define BCRF_SR_BANK 29
`define BCRF_SR_EMASK 28
`define BCRF_SR_RESET 32'h70003c00
`define BCRF_SR_WMASK 32'h70003ff3
`define BCRF_SR_UMASK 32'h00000303
`define BCRF_SR_EVENT 32'h70000000

// ==========================================================
// other reset values
`define BCRF_PC_RESET 32'ha0000000
`define BCRF_VBASE_RESET 32'h00000000

// ==========================================================
// control and system register selectors
`define BCRF_SEL_STATUS 4'h0
`define BCRF_SEL_GBASE 4'h1
`define BCRF_SEL_SSTAT 4'h2
`define BCRF_SEL_SRET 4'h3
`define BCRF_SEL_VBASE 4'h4
`define BCRF_SEL_MULT_ACC_HIGH 4'h5
`define BCRF_SEL_MULT_ACC_LOW 4'h6
`define BCRF_SEL_LINK 4'h7

`endif

// [bcrf_register_file_sva.sv]
// assertion checker for the banked register file ports
`timescale 1ns/1ps
module bcrf_register_file_sva #(parameter DATA_W = 32) (
    input wire sys_clk,
    input wire rst_b,
    input wire ctl_rd_en,
    input wire [3:0] ctl_rd_sel,
    input wire ctl_rd_bank,
    input wire ctl_wr_en,
    input wire [DATA_W-1:0] ctl_rd_data_ff,
    input wire ctl_denied_ff,
    input wire [DATA_W-1:0] pc_ff,
    input wire exc_ack,
    input wire priv_mode,
    input wire bank_select_bit,
    input wire event_mask_flag,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // a bus write lands only at the edge that ends the wait
    wire bus_wr = avs_write && !avs_waitrequest;
    sequence s_exc_taken; exc_ack; endsequence
    sequence s_all_set; priv_mode && bank_select_bit && event_mask_flag; endsequence
    a_exc_enter: assert property (s_exc_taken |=> s_all_set)
        else $error("exception did not enter privileged state");
    a_mask_blocks: assert property (event_mask_flag |-> !exc_ack)
        else $error("exception taken while masked");
    a_user_stays: assert property (!priv_mode && !exc_ack && !bus_wr |=>
        !priv_mode && $stable(bank_select_bit)) else $error("user mode changed protected status bits");
    a_user_refuse: assert property (!priv_mode && ctl_rd_en && ctl_rd_sel inside {4'h2, 4'h3, 4'h4} |=>
        ctl_denied_ff && ctl_rd_data_ff == '0) else $error("privileged register read in user mode");
    a_bank_hidden: assert property (!priv_mode && ctl_rd_en && ctl_rd_bank |=> ctl_denied_ff)
        else $error("inactive bank reached in user mode");
    a_ctl_open: assert property (!ctl_wr_en && ctl_rd_en && !ctl_rd_bank && ctl_rd_sel inside {4'h0, 4'h1, 4'h5, 4'h6, 4'h7}
        |=> !ctl_denied_ff) else $error("open register refused");
    a_reset_vals: assert property ($rose(rst_b) |-> pc_ff == 32'ha0000000 && priv_mode
        && bank_select_bit && event_mask_flag) else $error("wrong reset values");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait longer than one cycle");
endmodule // bcrf_register_file_sva
bind bcrf_register_file bcrf_register_file_sva #(.DATA_W(DATA_W)) bcrf_register_file_sva_i (.sys_clk, .rst_b,
    .ctl_rd_en, .ctl_rd_sel, .ctl_rd_bank, .ctl_wr_en, .ctl_rd_data_ff, .ctl_denied_ff, .pc_ff, .exc_ack, .priv_mode,
    .bank_select_bit, .event_mask_flag, .avs_read, .avs_write, .avs_waitrequest);

// [bcrf_core_model.sv]
// core model issuing register file requests, one op task at a time
`timescale 1ns/1ps
module bcrf_core_model (
    input wire sys_clk,
    output logic [3:0] rd_a_idx,
    output logic [31:0] wr_data,
    output logic wr_en,
    output logic ctl_rd_en,
    output logic ctl_wr_en,
    output logic ctl_rd_bank,
    output logic pend
);
    initial {rd_a_idx, wr_data, wr_en, ctl_rd_en, ctl_wr_en, ctl_rd_bank, pend} = '0;
    // k: 0 general write, 1 general read, 2 control write, 3 control read
    task op(input logic [1:0] k, input logic [3:0] i, input logic b, input logic [31:0] d);
        @(posedge sys_clk);
        rd_a_idx <= i;
        ctl_rd_bank <= b;
        wr_data <= d;
        wr_en <= k == 2'd0;
        ctl_wr_en <= k == 2'd2;
        ctl_rd_en <= k == 2'd3;
        pend <= k[0];
        @(posedge sys_clk);
        {wr_en, ctl_wr_en, ctl_rd_en, pend} <= 4'h0;
        // stale data must not look valid once the strobe is gone
        wr_data <= ~d;
    endtask
endmodule // bcrf_core_model

// [bcrf_register_file_tb_top.sv]
// self-checking bench for the banked register file
`timescale 1ns/1ps
module bcrf_register_file_tb_top;
    logic sys_clk = 1'b0, rst_b = 1'b0, exc_req = 1'b0, pc_load_en = 1'b0, fp_zero_wr_en = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, chk_d = 1'b0;
    logic [3:0] rd_b_idx = 4'h0, avs_byteenable = 4'hf;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] pc_load_data = 32'h0, fp_zero_wr_data = 32'h0, avs_writedata = 32'h0;
    wire [3:0] rd_a_idx;
    wire [31:0] wr_data, rd_a_data_ff, rd_b_data_ff, ctl_rd_data_ff, pc_ff;
    wire [31:0] fp_reg_zero_ff, index_reg_zero_ff, avs_readdata_ff;
    wire wr_en, ctl_rd_en, ctl_wr_en, ctl_rd_bank, pend, ctl_denied_ff, exc_ack, priv_mode;
    wire bank_select_bit, event_mask_flag, avs_waitrequest;
    typedef struct {logic [2:0] k; logic [32:0] v;} bcrf_note_t;
    bcrf_note_t note_q[$];
    int error_cnt = 0, n_tests = 0;
    always #20 sys_clk = ~sys_clk;
    bcrf_core_model bcrf_core_model_i (.sys_clk, .rd_a_idx, .wr_data, .wr_en, .ctl_rd_en, .ctl_wr_en,
        .ctl_rd_bank, .pend);
    bcrf_register_file bcrf_register_file_i (.sys_clk, .rst_b, .rd_a_idx, .rd_a_data_ff, .rd_b_idx, .rd_b_data_ff,
        .wr_en, .wr_idx(rd_a_idx), .wr_data, .ctl_rd_en, .ctl_rd_sel(rd_a_idx), .ctl_rd_bank, .ctl_rd_data_ff,
        .ctl_wr_en, .ctl_wr_sel(rd_a_idx), .ctl_wr_bank(ctl_rd_bank), .ctl_wr_data(wr_data), .ctl_denied_ff,
        .pc_load_en, .pc_load_data, .pc_ff, .fp_zero_wr_en, .fp_zero_wr_data, .fp_reg_zero_ff, .index_reg_zero_ff,
        .exc_req, .exc_ack, .priv_mode, .bank_select_bit, .event_mask_flag, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata_ff, .avs_waitrequest);
    task stop_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task cmp(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // core results land one edge after the request, bus data at the edge ending the wait
    always @(posedge sys_clk) begin
        bcrf_note_t nt;
        if (chk_d || (avs_read && !avs_waitrequest)) begin
            nt = note_q.pop_front();
            case (nt.k)
                3'd1: begin
                    cmp(nt.v, {1'b0, rd_a_data_ff});
                    cmp(nt.v, {1'b0, rd_b_data_ff});
                end
                3'd2: cmp(nt.v, {1'b0, index_reg_zero_ff});
                3'd3: cmp(nt.v, {ctl_denied_ff, ctl_rd_data_ff});
                3'd4: cmp(nt.v, {1'b0, fp_reg_zero_ff});
                3'd5: cmp(nt.v, {30'h0, priv_mode, bank_select_bit, event_mask_flag});
                3'd7: cmp(nt.v, {1'b0, pc_ff});
                default: cmp(nt.v, {1'b0, avs_readdata_ff});
            endcase
        end
        chk_d <= pend;
    end
    task chk(input logic [2:0] k, input logic [3:0] i, input logic b, input logic [32:0] e);
        note_q.push_back('{k, e});
        rd_b_idx <= i;
        bcrf_core_model_i.op((k == 3'd3) ? 2'd3 : 2'd1, i, b, 32'h0);
    endtask
    // for a read, d is the expected data
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        if (!w) note_q.push_back('{3'd6, {1'b0, d}});
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= w ? d : ~d;
        avs_write <= w;
        avs_read <= !w;
        // the request stands until the rising edge that sees waitrequest low
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            stop_test();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // w: 0 exception request, 1 pc load, 2 fp zero load
    task drive(input logic [1:0] w, input logic [31:0] d);
        @(posedge sys_clk);
        exc_req <= w == 2'd0;
        pc_load_en <= w == 2'd1;
        fp_zero_wr_en <= w == 2'd2;
        pc_load_data <= d;
        fp_zero_wr_data <= d;
        rd_b_idx <= d[3:0];
        @(posedge sys_clk);
        {exc_req, pc_load_en, fp_zero_wr_en} <= 3'h0;
    endtask
    initial begin
        logic [31:0] g[16], b0[8], v, p;
        void'($urandom(65312));
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus(1'b0, 6'h00, 32'h70003c00);
        bus(1'b0, 6'h04, 32'ha0000000);
        bus(1'b0, 6'h08, 32'h0);
        bus(1'b0, 6'h10, 32'h0);
        for (int i = 0; i < 16; i++) begin
            g[i] = $urandom;
            bcrf_core_model_i.op(2'd0, 4'(i), 1'b0, g[i]);
            if (i < 8) begin
                b0[i] = $urandom;
                bcrf_core_model_i.op(2'd2, 4'(i), 1'b1, b0[i]);
            end
        end
        for (int i = 0; i < 16; i++) chk(3'd1, 4'(i), 1'b0, {1'b0, g[i]});
        for (int i = 0; i < 8; i++) chk(3'd3, 4'(i), 1'b1, {1'b0, b0[i]});
        bus(1'b1, 6'h00, 32'h50000000);
        for (int i = 0; i < 8; i++) chk(3'd1, 4'(i), 1'b0, {1'b0, b0[i]});
        for (int i = 0; i < 8; i++) chk(3'd3, 4'(i), 1'b1, {1'b0, g[i]});
        bus(1'b1, 6'h00, 32'h30000000);
        for (int i = 0; i < 8; i++) chk(3'd1, 4'(i), 1'b0, {1'b0, b0[i]});
        chk(3'd3, 4'h1, 1'b1, 33'h100000000);
        for (int s = 1; s < 16; s++) begin
            v = $urandom;
            bcrf_core_model_i.op(2'd2, 4'(s), 1'b0, v);
            chk(3'd3, 4'(s), 1'b0, (s inside {1, 5, 6, 7}) ? {1'b0, v} : 33'h100000000);
        end
        bus(1'b0, 6'h08, 32'h0);
        bcrf_core_model_i.op(2'd2, 4'h0, 1'b0, 32'hffffffff);
        chk(3'd3, 4'h0, 1'b0, 33'h030000303);
        drive(2'd0, 32'h0);
        chk(3'd5, 4'h0, 1'b0, 33'h3);
        p = $urandom;
        drive(2'd1, p);
        chk(3'd7, 4'h0, 1'b0, {1'b0, p});
        bus(1'b0, 6'h04, p);
        bus(1'b1, 6'h00, 32'h3);
        drive(2'd0, 32'h0);
        chk(3'd5, 4'h0, 1'b0, 33'h7);
        chk(3'd3, 4'h2, 1'b0, 33'h3);
        chk(3'd3, 4'h3, 1'b0, {1'b0, p});
        chk(3'd2, 4'h0, 1'b0, {1'b0, g[0]});
        v = $urandom;
        drive(2'd2, v);
        chk(3'd4, 4'h0, 1'b0, {1'b0, v});
        bus(1'b1, 6'h08, v);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus(1'b0, 6'h08, 32'h0);
        bus(1'b0, 6'h00, 32'h70003c00);
        // only the two low bytes enabled
        avs_byteenable <= 4'h3;
        bus(1'b1, 6'h08, 32'hffffffff);
        avs_byteenable <= 4'hf;
        bus(1'b0, 6'h08, 32'h0000ffff);
        // let the last pending compare happen before the verdict
        repeat (2) @(posedge sys_clk);
        if (note_q.size() != 0) error_cnt++;
        stop_test();
    end
endmodule // bcrf_register_file_tb_top
